/* bcde_pkg.sv */
`default_nettype none
package bcde_pkg;
	// ----------------------------------------
	// Register byte offsets on the APB side
	// ----------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FLAGS = 8'h04;
	localparam logic [7:0] A_ACC = 8'h08;
	localparam logic [7:0] A_BANK = 8'h0C;
	localparam logic [7:0] A_PC = 8'h10;
	localparam logic [7:0] A_TOS = 8'h14;
	localparam logic [7:0] A_SHADOW = 8'h18;
	localparam logic [7:0] A_INDEX = 8'h1C;
	localparam logic [7:0] A_STATE = 8'h20;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int CTRL_EXT = 1;
	localparam int F_C = 0;
	localparam int F_DC = 1;
	localparam int F_Z = 2;
	localparam int F_OV = 3;
	localparam int F_N = 4;
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [3:0] RST_BANK = 4'h0;
	localparam logic [11:0] RST_INDEX = 12'h000;
	// ----------------------------------------
	// Opcodes, addressing and arithmetic constants
	// ----------------------------------------
	localparam logic [7:0] OP_BZ = 8'hE0;
	localparam logic [6:0] OP_CALL1 = 7'h76;
	localparam logic [3:0] OP_CALL2 = 4'hF;
	localparam logic [15:0] OP_DAW = 16'h0007;
	localparam logic [5:0] OP_DEC = 6'h01;
	localparam logic [7:0] IDX_MAX = 8'h5F;
	localparam logic [7:0] ACC_SPLIT = 8'h60;
	localparam logic [3:0] ACC_HI_BANK = 4'hF;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_ADJ = 4'h6;
	localparam int PC_STEP = 2;
	localparam int CALL_RET = 4;
	// ----------------------------------------
	// State encodings
	// ----------------------------------------
	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001, PH_Q2 = 4'b0010, PH_Q3 = 4'b0100, PH_Q4 = 4'b1000
	} bcde_phase_t;
	typedef enum logic [4:0] {
		K_NONE = 5'b00001, K_BZ = 5'b00010, K_CALL = 5'b00100,
		K_DAW = 5'b01000, K_DEC = 5'b10000
	} bcde_kind_t;
	typedef enum logic [2:0] {
		S_RUN = 3'b001, S_FLUSH = 3'b010, S_CALL2 = 3'b100
	} bcde_seq_t;
endpackage
`default_nettype wire

/* bcde_exec.sv */
// Operation
// (RQ1) Zero flag set: branch loads PC plus two plus doubled offset; else falls through.
// (RQ2) Branch offset is two's complement, doubled, added to already advanced PC.
// (RQ3) Branch takes one cycle untaken, two taken; extra cycle does nothing.
// (RQ4) Call pushes PC plus four onto the return stack top.
// (RQ5) Call loads its 20-bit literal into PC bits 20 to 1.
// (RQ6) Shadow bit set: call copies accumulator, flags, bank select into shadows.
// (RQ7) Call is two words: 1110110 s k7:0, then 1111 k19:8.
// (RQ8) Decimal adjust corrects accumulator after BCD addition, touching only carry.
// (RQ9) Add six to nibble above nine or with its carry; carry propagates upward.
// (RQ10) Decrement subtracts one from file register, updating C, DC, N, OV, Z.
// (RQ11) Destination bit zero writes accumulator; one writes the file register back.
// (RQ12) Access bit zero uses access bank; one takes bank from bank select.
// (RQ13) Access zero with extended set and address up to 95 uses indexed offset.
// (RQ14) Decrement decodes from 000001 d a f7:0 and runs in one cycle.
// (RQ15) Branch offset is sign-extended to PC width before doubling.
`timescale 1ns/1ns
`default_nettype none
module bcde_exec import bcde_pkg::*; #(
	parameter int PC_W = 21
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [PC_W-1:0] prog_addr,
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	output logic instr_take,
	output logic [11:0] file_addr,
	output logic file_rd,
	input wire logic [7:0] file_rd_data,
	output logic file_wr,
	output logic [7:0] file_wdata,
	output logic [PC_W-1:0] return_stack_top,
	output logic ret_push
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	// Call literal fills bits 20:1 exactly, so the counter cannot be resized
	if (PC_W != 21) begin : g_bad_pc_w
		$error("PC_W must be 21");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	bcde_phase_t phase_q;
	bcde_kind_t kind_q, kind_d;
	bcde_seq_t seq_q;
	logic run_q, ext_q;
	logic [15:0] ir_q;
	logic [7:0] k_lo_q;
	logic [PC_W-1:0] pc_q, tos_q;
	logic [7:0] acc_q, acc_sh_q;
	logic [4:0] flags_q, flags_sh_q;
	logic [3:0] bank_q, bank_sh_q;
	logic [11:0] index_q, addr_d;
	logic instr_take_q, ret_push_q;
	logic file_rd_q, file_wr_q;
	logic [11:0] file_addr_q;
	logic [7:0] file_wdata_q;
	logic [31:0] prdata_q, rd_mux;
	logic pready_q, pslverr_q, mapped;
	logic setup, apb_wr;
	logic q1_adv, q1_acc, ex3, ex4;
	logic [PC_W-1:0] step2, ret4, bz_off2, bz_target, call_tgt;
	logic bz_taken;
	logic [4:0] lo_sum, hi_sum;
	logic lo_fix, hi_fix, daw_c;
	logic [7:0] daw_res, dec_res;
	logic [4:0] dec_flags;

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prog_addr = pc_q;
	assign instr_take = instr_take_q;
	assign file_addr = file_addr_q;
	assign file_rd = file_rd_q;
	assign file_wr = file_wr_q;
	assign file_wdata = file_wdata_q;
	assign return_stack_top = tos_q;
	assign ret_push = ret_push_q;

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	assign setup = psel & ~penable;
	assign apb_wr = psel & penable & pready_q & pwrite;

	// Read mux; unmapped addresses flag an error and read zero
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			A_CTRL: rd_mux = {30'h0, ext_q, run_q};
			A_FLAGS: rd_mux = {27'h0, flags_q};
			A_ACC: rd_mux = {24'h0, acc_q};
			A_BANK: rd_mux = {28'h0, bank_q};
			A_PC: rd_mux = 32'(pc_q);
			A_TOS: rd_mux = 32'(tos_q);
			A_SHADOW: rd_mux = {12'h0, bank_sh_q, 3'h0, flags_sh_q, acc_sh_q};
			A_INDEX: rd_mux = {20'h0, index_q};
			A_STATE: rd_mux = {20'h0, seq_q, kind_q, phase_q};
			default: mapped = 1'b0;
		endcase
	end

	// Answer one cycle after setup, so the access phase is one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Software-only control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			ext_q <= 1'b0;
			bank_q <= RST_BANK;
			index_q <= RST_INDEX;
		end else if (apb_wr) begin
			if (paddr == A_CTRL) begin
				run_q <= pwdata[CTRL_RUN];
				ext_q <= pwdata[CTRL_EXT];
			end
			if (paddr == A_BANK)
				bank_q <= pwdata[3:0];
			if (paddr == A_INDEX)
				index_q <= pwdata[11:0];
		end
	end

	// ----------------------------------------
	// Instruction cycle: four phases per cycle
	// ----------------------------------------
	assign q1_adv = run_q & (phase_q == PH_Q1) & (instr_valid | (seq_q == S_FLUSH));
	assign q1_acc = q1_adv & (seq_q != S_FLUSH);
	assign ex3 = run_q & (phase_q == PH_Q3);
	assign ex4 = run_q & (phase_q == PH_Q4);

	// Phase sequencer; stalls in Q1 until a word is offered, except in a flush cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= PH_Q1;
		end else if (!run_q) begin
			phase_q <= PH_Q1;
		end else begin
			unique case (phase_q)
				PH_Q1: if (q1_adv) phase_q <= PH_Q2;
				PH_Q2: phase_q <= PH_Q3;
				PH_Q3: phase_q <= PH_Q4;
				PH_Q4: phase_q <= PH_Q1;
			endcase
		end
	end

	// Decode of the offered word
	always_comb begin
		kind_d = K_NONE;
		if (seq_q == S_CALL2) begin
			kind_d = K_CALL;
		end else if (seq_q == S_RUN) begin
			if (instr_word[15:8] == OP_BZ)
				kind_d = K_BZ;
			else if (instr_word[15:9] == OP_CALL1) // [RQ7]
				kind_d = K_CALL;
			else if (instr_word == OP_DAW)
				kind_d = K_DAW;
			else if (instr_word[15:10] == OP_DEC) // [RQ14]
				kind_d = K_DEC;
		end
	end

	// File address: bank select, indexed offset or access bank
	always_comb begin
		if (instr_word[8])
			addr_d = {bank_q, instr_word[7:0]}; // [RQ12]
		else if (ext_q && instr_word[7:0] <= IDX_MAX)
			addr_d = index_q + {4'h0, instr_word[7:0]}; // [RQ13]
		else if (instr_word[7:0] < ACC_SPLIT)
			addr_d = {4'h0, instr_word[7:0]}; // [RQ12]
		else
			addr_d = {ACC_HI_BANK, instr_word[7:0]};
	end

	// Instruction latch; flush cycle takes no word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kind_q <= K_NONE;
			ir_q <= 16'h0000;
			instr_take_q <= 1'b0;
		end else begin
			instr_take_q <= q1_acc;
			if (q1_adv)
				kind_q <= kind_d;
			if (q1_acc)
				ir_q <= instr_word;
		end
	end

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	// Offset sign-extended before doubling so backward targets wrap
	assign step2 = pc_q + PC_W'(PC_STEP);
	assign ret4 = pc_q + PC_W'(CALL_RET);
	assign bz_off2 = {{(PC_W-9){ir_q[7]}}, ir_q[7:0], 1'b0}; // [RQ2] [RQ15]
	assign bz_target = step2 + bz_off2; // [RQ1]
	assign bz_taken = (kind_q == K_BZ) & flags_q[F_Z];
	assign call_tgt = {ir_q[11:0], k_lo_q, 1'b0}; // [RQ5]

	// Packed BCD correction, low nibble carry feeds the high nibble
	assign lo_fix = (acc_q[3:0] > BCD_MAX) | flags_q[F_DC];
	assign lo_sum = {1'b0, acc_q[3:0]} + (lo_fix ? {1'b0, BCD_ADJ} : 5'h00); // [RQ9]
	// High digit is tested after the low carry lands, else 9 plus a carry stays A
	assign hi_fix = (({1'b0, acc_q[7:4]} + {4'h0, lo_sum[4]}) > {1'b0, BCD_MAX})
		| flags_q[F_C]; // [RQ9]
	assign hi_sum = {1'b0, acc_q[7:4]} + (hi_fix ? {1'b0, BCD_ADJ} : 5'h00)
		+ {4'h0, lo_sum[4]}; // [RQ9]
	assign daw_res = {hi_sum[3:0], lo_sum[3:0]};
	assign daw_c = hi_sum[4] | flags_q[F_C];

	// Decrement result and flags, borrow shown as carry clear
	assign dec_res = file_rd_data - 8'h01;
	assign dec_flags = {dec_res[7], file_rd_data == 8'h80, dec_res == 8'h00,
		file_rd_data[3:0] != 4'h0, file_rd_data != 8'h00}; // [RQ10]

	// File port: read in Q2, data back by Q3, write in Q4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			file_rd_q <= 1'b0;
			file_wr_q <= 1'b0;
			file_addr_q <= 12'h000;
			file_wdata_q <= 8'h00;
		end else begin
			file_rd_q <= q1_acc & (kind_d == K_DEC);
			file_wr_q <= ex3 & (kind_q == K_DEC) & ir_q[9]; // [RQ11]
			if (q1_acc && kind_d == K_DEC)
				file_addr_q <= addr_d;
			if (ex3 && kind_q == K_DEC)
				file_wdata_q <= dec_res;
		end
	end

	// Accumulator; core update wins over a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acc_q <= RST_ACC;
		else if (ex3 && kind_q == K_DAW)
			acc_q <= daw_res; // [RQ8]
		else if (ex3 && kind_q == K_DEC && !ir_q[9])
			acc_q <= dec_res; // [RQ11]
		else if (apb_wr && paddr == A_ACC)
			acc_q <= pwdata[7:0];
	end

	// Status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flags_q <= RST_FLAGS;
		else if (ex3 && kind_q == K_DEC)
			flags_q <= dec_flags; // [RQ10]
		else if (ex3 && kind_q == K_DAW)
			flags_q[F_C] <= daw_c; // [RQ8]
		else if (apb_wr && paddr == A_FLAGS)
			flags_q <= pwdata[4:0];
	end

	// Call first word: push return address, optional shadow copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tos_q <= '0;
			ret_push_q <= 1'b0;
			k_lo_q <= 8'h00;
			acc_sh_q <= RST_ACC;
			flags_sh_q <= RST_FLAGS;
			bank_sh_q <= RST_BANK;
		end else begin
			ret_push_q <= ex3 & (kind_q == K_CALL) & (seq_q == S_RUN);
			if (ex3 && kind_q == K_CALL && seq_q == S_RUN) begin
				tos_q <= ret4; // [RQ4]
				k_lo_q <= ir_q[7:0];
				if (ir_q[8]) begin
					acc_sh_q <= acc_q; // [RQ6]
					flags_sh_q <= flags_q;
					bank_sh_q <= bank_q;
				end
			end else if (apb_wr && paddr == A_TOS) begin
				tos_q <= pwdata[PC_W-1:0];
			end
		end
	end

	// Program counter, updated in Q4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= '0;
		end else if (ex4) begin
			if (seq_q == S_CALL2)
				pc_q <= (ir_q[15:12] == OP_CALL2) ? call_tgt : step2; // [RQ7]
			else if (seq_q == S_RUN && bz_taken)
				pc_q <= bz_target; // [RQ1]
			else if (seq_q == S_RUN)
				pc_q <= step2;
		end else if (apb_wr && paddr == A_PC) begin
			pc_q <= pwdata[PC_W-1:0];
		end
	end

	// Cycle sequencing: taken branch adds an idle cycle, call a second word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_q <= S_RUN;
		end else if (ex4) begin
			unique case (seq_q)
				S_RUN: begin
					if (bz_taken)
						seq_q <= S_FLUSH; // [RQ3]
					else if (kind_q == K_CALL)
						seq_q <= S_CALL2;
				end
				S_FLUSH: seq_q <= S_RUN;
				S_CALL2: seq_q <= S_RUN;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_bz_taken_pc: assert property (ex4 && seq_q == S_RUN && bz_taken // [RQ1] [RQ2]
		|=> pc_q == $past(pc_q) + PC_W'(PC_STEP) + $past(bz_off2))
		else $error("taken branch target wrong");
	a_bz_fall_pc: assert property (ex4 && seq_q == S_RUN && kind_q == K_BZ // [RQ1]
		&& !flags_q[F_Z] |=> pc_q == $past(pc_q) + PC_W'(PC_STEP) && seq_q == S_RUN)
		else $error("untaken branch did not fall through");
	a_bz_idle_cycle: assert property (ex4 && seq_q == S_RUN && bz_taken && run_q // [RQ3]
		|=> (!instr_take_q && !file_rd_q && !file_wr_q)[*5])
		else $error("taken branch idle cycle not idle");
	a_bz_back_wrap: assert property (ex4 && seq_q == S_RUN && bz_taken // [RQ15]
		&& ir_q == {OP_BZ, 8'hFF} |=> pc_q == $past(pc_q))
		else $error("backward offset not sign-extended");
	a_call_push: assert property (ex3 && kind_q == K_CALL && seq_q == S_RUN // [RQ4]
		|=> ret_push_q && tos_q == $past(pc_q) + PC_W'(CALL_RET) ##1 !ret_push_q)
		else $error("call return address wrong");
	a_call_target: assert property (ex4 && seq_q == S_CALL2 // [RQ5] [RQ7]
		&& ir_q[15:12] == OP_CALL2
		|=> pc_q == {$past(ir_q[11:0]), $past(k_lo_q), 1'b0} && seq_q == S_RUN)
		else $error("call target wrong");
	a_shadow_copy: assert property (ex3 && kind_q == K_CALL && seq_q == S_RUN // [RQ6]
		&& ir_q[8] |=> acc_sh_q == $past(acc_q) && flags_sh_q == $past(flags_q)
		&& bank_sh_q == $past(bank_q))
		else $error("shadow copy missing");
	a_shadow_keep: assert property (ex3 && kind_q == K_CALL && !ir_q[8] // [RQ6]
		|=> $stable(acc_sh_q) && $stable(flags_sh_q) && $stable(bank_sh_q))
		else $error("shadows changed without shadow bit");
	a_daw_only_c: assert property (ex3 && kind_q == K_DAW // [RQ8]
		|=> flags_q[4:1] == $past(flags_q[4:1]))
		else $error("decimal adjust touched a flag other than carry");
	a_daw_low_keep: assert property (ex3 && kind_q == K_DAW // [RQ9]
		&& acc_q[3:0] <= BCD_MAX && !flags_q[F_DC]
		|=> acc_q[3:0] == $past(acc_q[3:0]))
		else $error("valid low digit altered");
	a_dec_to_acc: assert property (ex3 && kind_q == K_DEC && !ir_q[9] // [RQ10] [RQ11]
		|=> acc_q == $past(file_rd_data) - 8'h01 && !file_wr_q)
		else $error("decrement to accumulator wrong");
	a_dec_to_file: assert property (ex3 && kind_q == K_DEC && ir_q[9] // [RQ11]
		|=> file_wr_q && file_wdata_q == $past(file_rd_data) - 8'h01 ##1 !file_wr_q)
		else $error("decrement write-back wrong");
	a_dec_zero_flag: assert property (ex3 && kind_q == K_DEC // [RQ10]
		&& file_rd_data == 8'h01 |=> flags_q[F_Z] && flags_q[F_C] && !flags_q[F_N])
		else $error("decrement flags wrong");
	a_dec_bank_addr: assert property (q1_acc && kind_d == K_DEC && instr_word[8] // [RQ12]
		|=> file_rd_q && file_addr_q == {$past(bank_q), $past(instr_word[7:0])})
		else $error("banked file address wrong");
	a_dec_indexed: assert property (q1_acc && kind_d == K_DEC && !instr_word[8] // [RQ13]
		&& ext_q && instr_word[7:0] <= IDX_MAX
		|=> file_addr_q == $past(index_q) + {4'h0, $past(instr_word[7:0])})
		else $error("indexed file address wrong");
	a_dec_one_cycle: assert property (q1_acc && kind_d == K_DEC && run_q // [RQ14]
		|-> ##4 phase_q == PH_Q1 && seq_q == S_RUN
		&& pc_q == $past(pc_q, 4) + PC_W'(PC_STEP))
		else $error("decrement not one cycle");
endmodule
`default_nettype wire

/* bcde_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------
// Program memory and register file model
// -----------------------------------------
module bcde_mem import bcde_pkg::*; (
	input wire logic pclk,
	input wire logic slow,
	input wire logic [20:0] prog_addr,
	output logic [15:0] instr_word,
	output logic instr_valid,
	input wire logic [11:0] file_addr,
	input wire logic file_rd,
	output logic [7:0] file_rd_data,
	input wire logic file_wr,
	input wire logic [7:0] file_wdata
);
	logic [15:0] pmem [int];
	logic [7:0] rf [4096];
	logic [20:0] last_q = '0;
	logic [3:0] age_q = '0;
	logic rd_q = 1'b0;
	logic tgl_q = 1'b0;
	// Address age for slow fetches, read strobe delay, writes
	always @(posedge pclk) begin
		tgl_q <= ~tgl_q;
		last_q <= prog_addr;
		age_q <= (prog_addr != last_q) ? 4'h0 : ((age_q == 4'hF) ? age_q : age_q + 4'h1);
		rd_q <= file_rd;
		if (file_wr) begin
			rf[file_addr] <= file_wdata;
		end
	end
	// Stale buses toggle so a leftover value never passes for data
	always @* begin
		instr_valid = !slow || (prog_addr == last_q && age_q >= 4'h3);
		instr_word = {16{tgl_q}} ^ 16'h3C3C;
		if (instr_valid) begin
			instr_word = pmem.exists(int'(prog_addr)) ? pmem[int'(prog_addr)] : 16'h0000;
		end
		file_rd_data = rd_q ? rf[file_addr] : ({8{tgl_q}} ^ 8'hC3);
	end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb import bcde_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, instr_valid, instr_take, file_rd, file_wr, ret_push;
	logic [20:0] prog_addr, return_stack_top;
	logic [15:0] instr_word;
	logic [11:0] file_addr;
	logic [7:0] file_rd_data, file_wdata, r, a, b, acc_in, acc_ex;
	logic dc, c_in, c_ex;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	int last_take = 0;
	int dsum;
	logic [33:0] apb_q [$];
	logic [30:0] ev_q [$];
	logic [24:0] ft_q [$];
	logic [33:0] an;
	logic [30:0] en;
	logic [24:0] fn;
	logic [7:0] rst_a [7] = '{A_CTRL, A_FLAGS, A_ACC, A_BANK, A_PC, A_TOS, A_INDEX};
	logic [15:0] prog_c [6] = '{16'hE005, 16'h065F, 16'h0734, 16'h0470, 16'hED45, 16'hF123};

	always #25 pclk = ~pclk;

	bcde_exec #(.PC_W(21)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
		.instr_word(instr_word), .instr_valid(instr_valid), .instr_take(instr_take),
		.file_addr(file_addr), .file_rd(file_rd), .file_rd_data(file_rd_data),
		.file_wr(file_wr), .file_wdata(file_wdata), .return_stack_top(return_stack_top),
		.ret_push(ret_push));
	bcde_mem mem (.pclk(pclk), .slow(slow), .prog_addr(prog_addr), .instr_word(instr_word),
		.instr_valid(instr_valid), .file_addr(file_addr), .file_rd(file_rd),
		.file_rd_data(file_rd_data), .file_wr(file_wr), .file_wdata(file_wdata));

	// -----------------------------------------
	// Shared helpers
	// -----------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			fails++;
		end
	endtask

	task wrap_up();
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// One APB transfer; a read notes its expected data, a write only the error
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic er);
		int n;
		n = 0;
		apb_q.push_back({~w, er, w ? 32'h0 : d});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) fails++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task ft(input logic [3:0] g, input logic [20:0] ad);
		ft_q.push_back({g, ad});
	endtask

	task ev(input logic [1:0] k, input logic [20:0] ad, input logic [7:0] d);
		ev_q.push_back({k, ad, d});
	endtask

	// Start the core at a given PC, let it run, then stop it
	task run_to(input logic [20:0] pc, input logic [31:0] ctl, input int n);
		apb(1'b1, A_PC, {11'h0, pc}, 1'b0);
		apb(1'b1, A_CTRL, ctl, 1'b0);
		repeat (n) @(posedge pclk);
		apb(1'b1, A_CTRL, 32'h0, 1'b0);
	endtask

	// -----------------------------------------
	// Output watcher: pops the oldest note per result
	// -----------------------------------------
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc > 20000) begin
			fails++;
			wrap_up();
		end
		if (psel && penable && pready === 1'b1 && apb_q.size() > 0) begin
			an = apb_q.pop_front();
			chk("pslverr", {31'h0, an[32]}, {31'h0, pslverr});
			if (an[33]) chk("prdata", an[31:0], prdata);
		end
		// Fetch order and spacing between instruction takes
		if (instr_take === 1'b1) begin
			if (ft_q.size() > 0) begin
				fn = ft_q.pop_front();
				chk("prog_addr", {11'h0, fn[20:0]}, {11'h0, prog_addr});
				if (fn[24:21] != 4'h0) chk("take_gap", {28'h0, fn[24:21]}, 32'(cyc - last_take));
			end
			last_take = cyc;
		end
		// Any extra pulse with no note left is a mismatch
		if (file_rd === 1'b1 || file_wr === 1'b1 || ret_push === 1'b1) begin
			en = (ev_q.size() > 0) ? ev_q.pop_front() : 31'h7FFFFFFF;
			chk("event_kind", {30'h0, en[30:29]}, {30'h0, ret_push, file_wr});
			chk("event_addr", {11'h0, en[28:8]},
				{11'h0, ret_push ? return_stack_top : {9'h0, file_addr}});
			if (file_wr === 1'b1) chk("file_wdata", {24'h0, en[7:0]}, {24'h0, file_wdata});
		end
	end

	// -----------------------------------------
	// Main sequence
	// -----------------------------------------
	initial begin
		void'($urandom(32'h0BB6));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_a[i]) apb(1'b0, rst_a[i], 32'h0, 1'b0);
		apb(1'b0, 8'h24, 32'h0, 1'b1);
		apb(1'b1, 8'h30, 32'h0000_00FF, 1'b1);
		// Decimal adjust, then a backward branch onto itself
		mem.pmem[0] = OP_DAW;
		mem.pmem[2] = 16'hE0FF;
		for (int i = 0; i < 6; i++) begin
			a = 8'(($urandom % 10) * 16 + $urandom % 10);
			b = 8'(($urandom % 10) * 16 + $urandom % 10);
			acc_in = a + b;
			dc = (a[3:0] + b[3:0]) > 15;
			c_in = (a + 9'h0 + b) > 255;
			dsum = a[7:4] * 10 + a[3:0] + b[7:4] * 10 + b[3:0];
			acc_ex = {4'(dsum / 10 % 10), 4'(dsum % 10)};
			c_ex = dsum > 99;
			if (i < 2) begin
				acc_in = (i == 0) ? 8'hA5 : 8'hCE;
				acc_ex = (i == 0) ? 8'h05 : 8'h34;
				{dc, c_in, c_ex} = 3'b001;
			end
			slow <= (i >= 4);
			apb(1'b1, A_ACC, {24'h0, acc_in}, 1'b0);
			apb(1'b1, A_FLAGS, 32'((1 << F_Z) | (dc << F_DC) | (c_in << F_C)), 1'b0);
			ft(4'h0, 21'h0);
			ft((i >= 4) ? 4'h0 : 4'h4, 21'h2);
			ft((i >= 4) ? 4'h0 : 4'h8, 21'h2);
			run_to(21'h0, 32'h1, 48);
			apb(1'b0, A_ACC, {24'h0, acc_ex}, 1'b0);
			apb(1'b0, A_FLAGS, 32'((1 << F_Z) | (dc << F_DC) | (c_ex << F_C)), 1'b0);
			apb(1'b0, A_PC, 32'h2, 1'b0);
		end
		// Untaken branch, three decrements, shadowing call
		slow <= 1'b0;
		r = 8'($urandom);
		mem.rf[12'h44F] = r;
		mem.rf[12'h534] = 8'h00;
		mem.rf[12'hF70] = 8'h80;
		foreach (prog_c[i]) mem.pmem[32'h100 + 2 * i] = prog_c[i];
		apb(1'b1, A_BANK, 32'h5, 1'b0);
		apb(1'b1, A_INDEX, 32'h3F0, 1'b0);
		apb(1'b1, A_FLAGS, 32'h0, 1'b0);
		apb(1'b1, A_ACC, 32'h11, 1'b0);
		ev(2'd0, 21'h44F, 8'h00);
		ev(2'd1, 21'h44F, r - 8'h01);
		ev(2'd0, 21'h534, 8'h00);
		ev(2'd1, 21'h534, 8'hFF);
		ev(2'd0, 21'hF70, 8'h00);
		ev(2'd2, 21'h10C, 8'h00);
		ft(4'h0, 21'h100);
		for (int i = 1; i < 6; i++) ft(4'h4, 21'(32'h100 + 2 * i));
		ft(4'h4, 21'h2468A);
		ft(4'h4, 21'h2468C);
		run_to(21'h100, 32'h3, 60);
		apb(1'b0, A_ACC, 32'h7F, 1'b0);
		apb(1'b0, A_FLAGS, 32'h09, 1'b0);
		apb(1'b0, A_TOS, 32'h10C, 1'b0);
		apb(1'b0, A_SHADOW, 32'h0005_097F, 1'b0);
		apb(1'b0, A_BANK, 32'h5, 1'b0);
		@(posedge pclk);
		chk("notes_left", 32'h0, 32'(apb_q.size() + ev_q.size() + ft_q.size()));
		wrap_up();
	end
endmodule
`default_nettype wire
